//--- rtl/crm_pkg.sv
// constants for the receive mailbox and interrupt block
// Summary of operation
// RULE1: every event source has its own enable; only enabled events request interrupts
// RULE2: after reset only message received and bus-off events are enabled
// RULE3: sixteen receive mailboxes, one message type each
// RULE4: mailboxes numbered 0 to 15; the select field picks one for access
// RULE5: full-mode mailbox accepts only frames whose 11-bit identifier matches
// RULE6: per-mailbox interrupt enable gates the message received event of full-mode mailboxes
// RULE7: fourteen maskable event sources from transmitted to remote reply sent
// RULE8: full mode filters in hardware; basic mode interrupts on every frame
// RULE9: bus-off when transmit error count reaches 256; frames then ignored
// RULE10: sticky pending flag per source, OR of enabled flags, cleared singly
package crm_pkg;
    localparam int MB_COUNT = 16;
    localparam int ID_W = 11;
    localparam int EVT_COUNT = 14;
    localparam int TEC_W = 9;
    localparam logic [TEC_W-1:0] BUSOFF_LIMIT = 9'h100;
    // register byte offsets
    localparam logic [5:0] OFS_INT_PEND = 6'h00;
    localparam logic [5:0] OFS_INT_EN = 6'h04;
    localparam logic [5:0] OFS_MB_FULL = 6'h08;
    localparam logic [5:0] OFS_MB_IRQEN = 6'h0c;
    localparam logic [5:0] OFS_MB_MODE = 6'h10;
    localparam logic [5:0] OFS_STATE = 6'h14;
    localparam logic [5:0] OFS_MB_SEL = 6'h18;
    localparam logic [5:0] OFS_MB_ID = 6'h1c;
    localparam logic [5:0] OFS_MB_DLO = 6'h20;
    localparam logic [5:0] OFS_MB_DHI = 6'h24;
    localparam logic [5:0] OFS_MB_DLC = 6'h28;
    // event bit positions
    localparam int EV_TX_DONE = 0;
    localparam int EV_RX_MSG = 1;
    localparam int EV_RX_FULL = 2;
    localparam int EV_BUS_OFF = 3;
    localparam int EV_CRC = 4;
    localparam int EV_FORM = 5;
    localparam int EV_ACK = 6;
    localparam int EV_STUFF = 7;
    localparam int EV_BIT = 8;
    localparam int EV_OVERLOAD = 9;
    localparam int EV_ARB_LOST = 10;
    localparam int EV_SST_FAIL = 11;
    localparam int EV_STUCK0 = 12;
    localparam int EV_RTR_SENT = 13;
    // reset values
    localparam logic [EVT_COUNT-1:0] INT_EN_RST = 14'h000a;
    localparam logic [MB_COUNT-1:0] MB_IRQEN_RST = 16'h0000;
    localparam logic [MB_COUNT-1:0] MB_MODE_RST = 16'h0000;
    localparam logic [ID_W-1:0] MB_ID_RST = 11'h000;
endpackage

//--- rtl/crm_rx_mailbox.sv
// receive mailboxes, acceptance filter and interrupt unit with avalon slave
`timescale 1ns/1ps
module crm_rx_mailbox
    import crm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // received frames from the protocol engine
    input wire logic rxValid,
    input wire logic [crm_pkg::ID_W-1:0] rxId,
    input wire logic [3:0] rxDlc,
    input wire logic [63:0] rxData,
    // event pulses and error counter
    input wire logic [crm_pkg::EVT_COUNT-1:0] evtPulse,
    input wire logic [crm_pkg::TEC_W-1:0] txErrCount,
    // status
    output logic busOff,
    output logic irq
);
    import crm_pkg::*;

    logic waitReq_r, waitReq_nxt;
    logic [31:0] rdData_r, rdData_nxt;
    logic [EVT_COUNT-1:0] pend_r, pend_nxt, intEn_r, intEn_nxt;
    logic [MB_COUNT-1:0] mbFull_r, mbFull_nxt, mbIrqEn_r, mbIrqEn_nxt;
    logic [MB_COUNT-1:0] mbMode_r, mbMode_nxt;
    logic [3:0] mbSel_r, mbSel_nxt;
    logic busOff_r, busOff_nxt, irq_r, irq_nxt;
    logic [ID_W-1:0] mbId_r [MB_COUNT];
    logic [ID_W-1:0] mbId_nxt [MB_COUNT];
    logic [63:0] mbData_r [MB_COUNT];
    logic [63:0] mbData_nxt [MB_COUNT];
    logic [3:0] mbDlc_r [MB_COUNT];
    logic [3:0] mbDlc_nxt [MB_COUNT];
    logic [31:0] wMask;
    logic wrTake, rdTake, hit, hitBasic;
    logic [3:0] hitIdx;
    logic [EVT_COUNT-1:0] evtSet;

    // byte-lane mask for register writes
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // acceptance: lowest matching full mailbox, else lowest basic one
    always_comb
    begin
        hit = 1'b0;
        hitBasic = 1'b0;
        hitIdx = 4'h0;
        for (int i = MB_COUNT - 1; i >= 0; i--)
        begin
            if (!mbMode_r[i])
            begin
                hitBasic = 1'b1;
                hitIdx = 4'(i);
            end
        end
        for (int i = MB_COUNT - 1; i >= 0; i--)
        begin
            if (mbMode_r[i] && mbId_r[i] == rxId) // RULE5 RULE8
            begin
                hit = 1'b1;
                hitBasic = 1'b0;
                hitIdx = 4'(i);
            end
        end
        hit = (hit | hitBasic) & rxValid & ~busOff_r; // RULE9
    end

    // bus slave: one wait cycle, then the answer edge
    always_comb
    begin
        rdTake = (read | write) & waitReq_r;
        wrTake = write & ~waitReq_r;
        wMask = lane_mask(byteenable);
        waitReq_nxt = ~rdTake;
        rdData_nxt = rdData_r;
        if (rdTake)
        begin
            rdData_nxt = 32'h0000_0000;
            if (read)
            begin
                unique case (address)
                    OFS_INT_PEND: rdData_nxt = 32'(pend_r);
                    OFS_INT_EN: rdData_nxt = 32'(intEn_r);
                    OFS_MB_FULL: rdData_nxt = 32'(mbFull_r);
                    OFS_MB_IRQEN: rdData_nxt = 32'(mbIrqEn_r);
                    OFS_MB_MODE: rdData_nxt = 32'(mbMode_r);
                    OFS_STATE: rdData_nxt = {15'h0000, busOff_r, 7'h00,
                        txErrCount};
                    OFS_MB_SEL: rdData_nxt = 32'(mbSel_r); // RULE4
                    OFS_MB_ID: rdData_nxt = 32'(mbId_r[mbSel_r]);
                    OFS_MB_DLO: rdData_nxt = mbData_r[mbSel_r][31:0];
                    OFS_MB_DHI: rdData_nxt = mbData_r[mbSel_r][63:32];
                    OFS_MB_DLC: rdData_nxt = 32'(mbDlc_r[mbSel_r]);
                    default: rdData_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    // configuration, mailboxes and pending flags
    always_comb
    begin
        intEn_nxt = intEn_r;
        mbIrqEn_nxt = mbIrqEn_r;
        mbMode_nxt = mbMode_r;
        mbSel_nxt = mbSel_r;
        mbId_nxt = mbId_r;
        mbData_nxt = mbData_r;
        mbDlc_nxt = mbDlc_r;
        mbFull_nxt = mbFull_r;
        pend_nxt = pend_r;
        busOff_nxt = txErrCount >= BUSOFF_LIMIT; // RULE9
        evtSet = evtPulse; // RULE7
        evtSet[EV_BUS_OFF] = busOff_nxt & ~busOff_r; // RULE9
        evtSet[EV_RX_MSG] = hit & (mbIrqEn_r[hitIdx] | ~mbMode_r[hitIdx]); // RULE6 RULE8
        evtSet[EV_RX_FULL] = hit & mbFull_r[hitIdx];
        if (wrTake)
        begin
            unique case (address)
                OFS_INT_PEND: pend_nxt = pend_r &
                    ~EVT_COUNT'(writedata & wMask); // RULE10
                OFS_INT_EN: intEn_nxt = EVT_COUNT'((writedata & wMask) |
                    (32'(intEn_r) & ~wMask)); // RULE1
                OFS_MB_FULL: mbFull_nxt = mbFull_r &
                    ~MB_COUNT'(writedata & wMask);
                OFS_MB_IRQEN: mbIrqEn_nxt = MB_COUNT'((writedata & wMask) |
                    (32'(mbIrqEn_r) & ~wMask)); // RULE6
                OFS_MB_MODE: mbMode_nxt = MB_COUNT'((writedata & wMask) |
                    (32'(mbMode_r) & ~wMask));
                OFS_MB_SEL: if (byteenable[0]) mbSel_nxt = writedata[3:0];
                OFS_MB_ID: mbId_nxt[mbSel_r] = ID_W'((writedata & wMask) |
                    (32'(mbId_r[mbSel_r]) & ~wMask)); // RULE5
                default: ;
            endcase
        end
        if (hit) // RULE3
        begin
            mbData_nxt[hitIdx] = rxData;
            mbDlc_nxt[hitIdx] = rxDlc;
            if (!mbMode_r[hitIdx])
                mbId_nxt[hitIdx] = rxId;
            mbFull_nxt[hitIdx] = 1'b1;
        end
        pend_nxt = pend_nxt | evtSet; // RULE10
        irq_nxt = |(pend_nxt & intEn_nxt); // RULE1 RULE10
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            waitReq_r <= 1'b1;
            rdData_r <= 32'h0000_0000;
            pend_r <= '0;
            intEn_r <= INT_EN_RST; // RULE2
            mbFull_r <= '0;
            mbIrqEn_r <= MB_IRQEN_RST;
            mbMode_r <= MB_MODE_RST;
            mbSel_r <= 4'h0;
            busOff_r <= 1'b0;
            irq_r <= 1'b0;
            for (int i = 0; i < MB_COUNT; i++)
            begin
                mbId_r[i] <= MB_ID_RST;
                mbData_r[i] <= 64'h0000_0000_0000_0000;
                mbDlc_r[i] <= 4'h0;
            end
        end
        else
        begin
            waitReq_r <= waitReq_nxt;
            rdData_r <= rdData_nxt;
            pend_r <= pend_nxt;
            intEn_r <= intEn_nxt;
            mbFull_r <= mbFull_nxt;
            mbIrqEn_r <= mbIrqEn_nxt;
            mbMode_r <= mbMode_nxt;
            mbSel_r <= mbSel_nxt;
            busOff_r <= busOff_nxt;
            irq_r <= irq_nxt;
            mbId_r <= mbId_nxt;
            mbData_r <= mbData_nxt;
            mbDlc_r <= mbDlc_nxt;
        end
    end

    assign readdata = rdData_r;
    assign waitrequest = waitReq_r;
    assign busOff = busOff_r;
    assign irq = irq_r;

    chk_irq_follows_pend: assert property ( // RULE1
        @(posedge clk) disable iff (!resetn)
        irq_r == |(pend_r & intEn_r)) else $error("irq mismatch");
    chk_reset_enables: assert property ( // RULE2
        @(posedge clk) !resetn |=> intEn_r == INT_EN_RST)
        else $error("bad enable reset");
    chk_store_sets_full: assert property ( // RULE3
        @(posedge clk) disable iff (!resetn)
        hit |=> mbFull_r[$past(hitIdx)]) else $error("mailbox not full");
    chk_full_mode_match: assert property ( // RULE5
        @(posedge clk) disable iff (!resetn)
        hit && mbMode_r[hitIdx] |-> mbId_r[hitIdx] == rxId)
        else $error("id mismatch stored");
    chk_mb_irq_gate: assert property ( // RULE6
        @(posedge clk) disable iff (!resetn)
        hit && mbMode_r[hitIdx] && !mbIrqEn_r[hitIdx] && !pend_r[EV_RX_MSG]
        && !evtPulse[EV_RX_MSG] |=> !pend_r[EV_RX_MSG])
        else $error("masked mailbox raised event");
    chk_basic_always: assert property ( // RULE8
        @(posedge clk) disable iff (!resetn)
        hit && !mbMode_r[hitIdx] |=> pend_r[EV_RX_MSG])
        else $error("basic frame missed");
    chk_busoff_drop: assert property ( // RULE9
        @(posedge clk) disable iff (!resetn)
        busOff_r |-> !hit) else $error("frame taken in bus-off");
    chk_busoff_event: assert property ( // RULE9
        @(posedge clk) disable iff (!resetn)
        $rose(busOff_r) |-> pend_r[EV_BUS_OFF])
        else $error("bus-off not flagged");
    chk_event_sticky: assert property ( // RULE7 RULE10
        @(posedge clk) disable iff (!resetn)
        evtPulse[EV_CRC] |=> pend_r[EV_CRC] ##1 (pend_r[EV_CRC] ||
        $past(wrTake && address == OFS_INT_PEND)))
        else $error("event lost");
    chk_bus_answer: assert property ( // RULE4
        @(posedge clk) disable iff (!resetn)
        (read || write) && waitReq_r |=> !waitReq_r ##1 waitReq_r)
        else $error("bus answer timing");
endmodule // crm_rx_mailbox

//--- test/crm_frame_src.sv
// frame and event source standing in for the protocol engine
`timescale 1ns/1ps
module crm_frame_src
    import crm_pkg::*;
(
    // clock
    input wire logic clk,
    // frame, event and error counter outputs
    output logic rxValid,
    output logic [crm_pkg::ID_W-1:0] rxId,
    output logic [3:0] rxDlc,
    output logic [63:0] rxData,
    output logic [crm_pkg::EVT_COUNT-1:0] evtPulse,
    output logic [crm_pkg::TEC_W-1:0] txErrCount
);
    initial
    begin
        rxValid = 1'b0;
        rxId = '0;
        rxDlc = '0;
        rxData = '0;
        evtPulse = '0;
        txErrCount = '0;
    end
    // one frame for one cycle; lines show garbage once released
    task automatic send(input logic [ID_W-1:0] id, input logic [3:0] dlc,
        input logic [63:0] d);
        rxValid <= 1'b1;
        rxId <= id;
        rxDlc <= dlc;
        rxData <= d;
        @(posedge clk);
        rxValid <= 1'b0;
        rxId <= ~id;
        rxDlc <= ~dlc;
        rxData <= ~d;
        @(posedge clk);
    endtask
    task automatic pulse(input int e);
        evtPulse <= EVT_COUNT'(1) << e;
        @(posedge clk);
        evtPulse <= '0;
    endtask
    task automatic setTec(input logic [TEC_W-1:0] v);
        txErrCount <= v;
        @(posedge clk);
    endtask
endmodule // crm_frame_src

//--- test/crm_rx_mailbox_tb.sv
// self-checking bench for the receive mailbox and interrupt block
`timescale 1ns/1ps
module crm_rx_mailbox_tb;
    import crm_pkg::*;
    logic clk, resetn, read, write, waitrequest, rxValid, busOff, irq;
    logic [5:0] address;
    logic [3:0] byteenable, rxDlc;
    logic [31:0] writedata, readdata;
    logic [31:0] expQ[$];
    logic [ID_W-1:0] rxId, id;
    logic [63:0] rxData, dat;
    logic [EVT_COUNT-1:0] evtPulse;
    logic [TEC_W-1:0] txErrCount;
    int errors = 0;
    int check_count = 0;
    int n;
    crm_rx_mailbox crm_rx_mailbox_inst (.clk(clk), .resetn(resetn),
        .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .rxValid(rxValid),
        .rxId(rxId), .rxDlc(rxDlc), .rxData(rxData), .evtPulse(evtPulse),
        .txErrCount(txErrCount), .busOff(busOff), .irq(irq));
    crm_frame_src crm_frame_src_inst (.clk(clk), .rxValid(rxValid),
        .rxId(rxId), .rxDlc(rxDlc), .rxData(rxData), .evtPulse(evtPulse),
        .txErrCount(txErrCount));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a,
        input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= w;
        read <= !w;
        n = 0;
        do @(posedge clk); while (waitrequest !== 1'b0 && n++ < 50);
        if (n >= 50) errors++;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        expQ.push_back(exp);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic chkIrq(input logic exp);
        @(posedge clk);
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, exp});
        @(posedge clk);
    endtask
    task automatic chkBo(input logic exp);
        @(negedge clk);
        chk({31'h0, busOff}, {31'h0, exp});
        @(posedge clk);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // read data taken at the edge where waitrequest is low
    always @(posedge clk)
        if (read === 1'b1 && waitrequest === 1'b0)
            chk(readdata, expQ.pop_front());
    initial
    begin
        #(20 * 20000);
        errors++;
        summarize();
    end
    initial
    begin
        resetn = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = '0;
        byteenable = 4'hf;
        writedata = '0;
        n = $urandom(69747);
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(OFS_INT_EN, 32'h0000000a);
        rd(OFS_MB_MODE, 32'h0);
        rd(6'h3c, 32'h0);
        $display("test reset values done");
        for (int e = 0; e < EVT_COUNT; e++)
            if (e == EV_TX_DONE || e > EV_BUS_OFF)
            begin
                crm_frame_src_inst.pulse(e);
                chkIrq(1'b0);
                rd(OFS_INT_PEND, 32'h1 << e);
                wr(OFS_INT_EN, 32'h1 << e);
                chkIrq(1'b1);
                wr(OFS_INT_PEND, 32'h1 << e);
                chkIrq(1'b0);
            end
        wr(OFS_INT_EN, 32'h0000000a);
        byteenable <= 4'h2;
        wr(OFS_INT_EN, 32'hffff_ffff);
        byteenable <= 4'hf;
        rd(OFS_INT_EN, 32'h00003f0a);
        wr(OFS_INT_EN, 32'h0000000a);
        $display("test event sources done");
        id = 11'($urandom) | 11'h001;
        dat = {$urandom, $urandom};
        wr(OFS_MB_SEL, 32'h5);
        wr(OFS_MB_ID, {21'h0, id});
        wr(OFS_MB_MODE, 32'h20);
        wr(OFS_MB_IRQEN, 32'h20);
        crm_frame_src_inst.send(id, 4'h8, dat);
        chkIrq(1'b1);
        rd(OFS_MB_FULL, 32'h20);
        rd(OFS_MB_ID, {21'h0, id});
        rd(OFS_MB_DLO, dat[31:0]);
        rd(OFS_MB_DHI, dat[63:32]);
        rd(OFS_MB_DLC, 32'h8);
        wr(OFS_INT_PEND, 32'h2);
        wr(OFS_MB_FULL, 32'hffff);
        crm_frame_src_inst.send(id ^ 11'h400, 4'h2, ~dat);
        chkIrq(1'b1);
        rd(OFS_MB_FULL, 32'h1);
        wr(OFS_INT_PEND, 32'h2);
        wr(OFS_MB_FULL, 32'hffff);
        wr(OFS_MB_MODE, 32'hffff);
        wr(OFS_MB_IRQEN, 32'h0);
        crm_frame_src_inst.send(id ^ 11'h200, 4'h1, dat);
        crm_frame_src_inst.send(id, 4'h1, dat);
        chkIrq(1'b0);
        rd(OFS_MB_FULL, 32'h20);
        rd(OFS_INT_PEND, 32'h0);
        wr(OFS_MB_FULL, 32'hffff);
        $display("test mailboxes done");
        crm_frame_src_inst.setTec(9'h0ff);
        rd(OFS_STATE, 32'h000000ff);
        chkBo(1'b0);
        crm_frame_src_inst.setTec(BUSOFF_LIMIT);
        chkIrq(1'b1);
        chkBo(1'b1);
        rd(OFS_STATE, 32'h00010100);
        rd(OFS_INT_PEND, 32'h8);
        crm_frame_src_inst.send(id, 4'h3, dat);
        rd(OFS_MB_FULL, 32'h0);
        $display("test bus off done");
        summarize();
    end
endmodule // crm_rx_mailbox_tb
